// *** mmp_pkg.sv ***
`default_nettype none
package mmp_pkg;
  // data-space word indices; byte address on the bus is four times the index
  localparam logic [7:0]  IDX_SRAM_LAST     = 8'h3F;
  localparam logic [7:0]  IDX_EE_FIRST      = 8'h40;
  localparam logic [7:0]  IDX_EE_UPPER      = 8'h60;
  localparam logic [7:0]  IDX_EE_LAST       = 8'h7F;
  localparam logic [7:0]  IDX_PERIPH_FIRST  = 8'h80;
  localparam logic [7:0]  IDX_PORT_DATA     = 8'hB2;
  localparam logic [7:0]  IDX_PORT_DIR      = 8'hB3;
  localparam logic [7:0]  IDX_INIT1_V       = 8'hB9;
  localparam logic [7:0]  IDX_TRIM_V        = 8'hBA;
  localparam logic [7:0]  IDX_INIT1_NV      = 8'hBB;
  localparam logic [7:0]  IDX_INIT2_NV      = 8'hBC;
  localparam logic [7:0]  IDX_PMC           = 8'hC0;
  localparam logic [7:0]  IDX_INIT3_V       = 8'hD0;
  localparam logic [7:0]  IDX_INIT3_NV      = 8'hD1;
  localparam logic [7:0]  IDX_INIT4_V       = 8'hD3;
  localparam logic [7:0]  IDX_INIT4_NV      = 8'hD4;
  // program-space indices
  localparam logic [11:0] IDX_CODE_FIRST    = 12'hC00;
  localparam logic [11:0] VEC_TIMER0        = 12'hFF6;
  localparam logic [11:0] VEC_PWM           = 12'hFF8;
  localparam logic [11:0] VEC_WAKEUP        = 12'hFFA;
  localparam logic [11:0] VEC_SOFT          = 12'hFFC;
  localparam logic [11:0] VEC_CONV          = 12'hFFE;
  // bus address layout
  localparam int          PROG_SPACE_BIT    = 14;
  localparam int          SRAM_DEPTH        = 64;
  localparam int          EE_DEPTH          = 64;
  localparam int          CODE_DEPTH        = 1024;
  // field positions
  localparam int          INIT4_DIR_BIT     = 7;
  localparam int          INIT4_LEV2_BIT    = 6;
  localparam int          INIT4_LEV1_BIT    = 5;
  localparam int          INIT1_CLK_ADJ_BIT = 7;
  localparam int          INIT1_UBD_BIT     = 2;
  localparam int          PIN_ONE           = 0;
  localparam int          PIN_TWO           = 5;
  // factory contents of the non-volatile copies, then the port register reset value
  localparam logic [7:0]  INIT1_NV_RST      = 8'h00;
  localparam logic [7:0]  INIT2_NV_RST      = 8'h80;
  localparam logic [7:0]  INIT3_NV_RST      = 8'h00;
  localparam logic [7:0]  INIT4_NV_RST      = 8'h10;
  localparam logic [7:0]  PORT_RST          = 8'h00;
  // data-phase steps
  localparam logic [1:0]  PH_IDLE           = 2'h0;
  localparam logic [1:0]  PH_ONE            = 2'h1;
  localparam logic [1:0]  PH_TWO            = 2'h2;
  localparam logic [1:0]  PH_THREE          = 2'h3;

  typedef enum logic [1:0] {
    LD_PINS = 2'b00,
    LD_REST = 2'b01,
    LD_RUN  = 2'b10
  } mmp_load_e;
endpackage
`default_nettype wire

// *** mmp_byte_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module mmp_byte_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  logic [7:0] mem_reg [DEPTH];

  // one shared address: the registered read runs every cycle and returns the old byte in a write cycle
  always_ff @(posedge clk) begin
    if (we) begin
      mem_reg[addr] <= wdata;
    end
    rdata <= mem_reg[addr];
  end
endmodule
`default_nettype wire

// *** mmp_memory_map.sv ***
// Notes on behaviour
// RULE_01: direction bit 0: inputs, level picks pull-up
// RULE_02: all three bits zero: tri-state inputs
// RULE_03: direction bit 1: push-pull outputs drive levels
// RULE_04: every register reachable through the address space
// RULE_05: init one copies at B9 and BB
// RULE_06: oscillator trim copy sits at BA
// RULE_07: init three copies at D0 and D1
// RULE_08: init four copies at D3 and D4
// RULE_09: power mode clear decoded at C0
// RULE_10: interrupt vectors from FF6 upward, two bytes
// RULE_11: default bits copied into port bits 0, 5
// RULE_12: init four shadow loaded first after reset
// RULE_13: SRAM, data EEPROM and code EEPROM windows
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mmp_memory_map
  import mmp_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic      [31:0] HRDATA,
  input  wire logic        PROG_MODE,
  output logic             PERIPH_SEL,
  output logic             PERIPH_WE,
  output logic      [7:0]  PERIPH_ADDR,
  output logic      [7:0]  PERIPH_WDATA,
  input  wire logic [7:0]  PERIPH_RDATA,
  output logic             POWER_MODE_CLEAR,
  input  wire logic [2:0]  VECTOR_SOURCE,
  output logic      [11:0] VECTOR_ADDRESS,
  output logic      [7:0]  PORT_OUT,
  output logic      [7:0]  PORT_OE,
  output logic      [7:0]  PORT_PULLUP,
  output logic      [7:0]  INIT_ONE,
  output logic      [7:0]  CLOCK_TRIM,
  output logic      [7:0]  INIT_THREE,
  output logic      [7:0]  INIT_FOUR,
  output logic             LOAD_DONE
);
  mmp_load_e   ld_state_reg;
  logic [1:0]  phase_reg;
  logic        dp_write_reg;
  logic        dp_prog_reg;
  logic        dp_ok_reg;
  logic [11:0] dp_idx_reg;
  logic [7:0]  wd_reg;
  logic [31:0] hrdata_reg;
  logic        pmc_reg;
  logic [11:0] vec_reg;
  logic [7:0]  init_one_v_reg;
  logic [7:0]  init_one_nv_reg;
  logic [7:0]  trim_v_reg;
  logic [7:0]  init_two_nv_reg;
  logic [7:0]  init_three_v_reg;
  logic [7:0]  init_three_nv_reg;
  logic [7:0]  init_four_v_reg;
  logic [7:0]  init_four_nv_reg;
  logic [7:0]  port_data_reg;
  logic [7:0]  port_dir_reg;
  logic [7:0]  sram_rdata;
  logic [7:0]  ee_rdata;
  logic [7:0]  code_rdata;
  logic [7:0]  local_rdata;
  logic [7:0]  d_idx;
  logic        accept;
  logic        capture_wd;
  logic        commit_wr;
  logic        capture_rd;
  logic        data_ok;
  logic        is_sram;
  logic        is_ee;
  logic        is_local;
  logic        is_periph;
  logic        is_code;
  logic        ee_upper_locked;

  // reset sequence: pin defaults first so the high-side pins settle early
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ld_state_reg <= LD_PINS;
    end else begin
      case (ld_state_reg)
        LD_PINS: ld_state_reg <= LD_REST; // RULE_12
        LD_REST: ld_state_reg <= LD_RUN;
        LD_RUN:  ld_state_reg <= LD_RUN;
        default: ld_state_reg <= LD_PINS;
      endcase
    end
  end
  assign LOAD_DONE = (ld_state_reg == LD_RUN);

  // bus handshake; the bus is held off until the shadows are loaded
  assign accept     = HSEL && HTRANS[1] && HREADY;
  assign capture_wd = (phase_reg == PH_ONE) && dp_write_reg;
  assign commit_wr  = (phase_reg == PH_TWO) && dp_write_reg;
  assign capture_rd = (phase_reg == PH_TWO) && !dp_write_reg;
  assign HREADYOUT  = LOAD_DONE && ((phase_reg == PH_IDLE) || (phase_reg == PH_THREE) || commit_wr);
  assign HRESP      = 1'b0;
  assign HRDATA     = hrdata_reg;

  // address phase latch and data-phase step counter
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      phase_reg    <= PH_IDLE;
      dp_write_reg <= 1'b0;
      dp_prog_reg  <= 1'b0;
      dp_ok_reg    <= 1'b0;
      dp_idx_reg   <= 12'h000;
    end else if (accept) begin
      phase_reg    <= PH_ONE;
      dp_write_reg <= HWRITE;
      dp_prog_reg  <= HADDR[PROG_SPACE_BIT];
      dp_ok_reg    <= (HADDR[31:15] == 17'h00000);
      dp_idx_reg   <= HADDR[13:2];
    end else begin
      case (phase_reg)
        PH_ONE:   phase_reg <= PH_TWO;
        PH_TWO:   phase_reg <= dp_write_reg ? PH_IDLE : PH_THREE;
        PH_THREE: phase_reg <= PH_IDLE;
        default:  phase_reg <= PH_IDLE;
      endcase
    end
  end

  // write data is caught in the wait cycle so the commit never looks at the live bus
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      wd_reg <= 8'h00;
    end else if (capture_wd) begin
      wd_reg <= HWDATA[7:0];
    end
  end

  // decode of the latched index
  assign d_idx     = dp_idx_reg[7:0];
  assign data_ok   = dp_ok_reg && !dp_prog_reg && (dp_idx_reg[11:8] == 4'h0);
  assign is_sram   = data_ok && (d_idx <= IDX_SRAM_LAST); // RULE_13
  assign is_ee     = data_ok && (d_idx >= IDX_EE_FIRST) && (d_idx <= IDX_EE_LAST); // RULE_13
  assign is_code   = dp_ok_reg && dp_prog_reg && (dp_idx_reg >= IDX_CODE_FIRST); // RULE_13
  assign is_local  = data_ok && ((d_idx == IDX_PORT_DATA) || (d_idx == IDX_PORT_DIR) || (d_idx == IDX_INIT1_V) ||
                     (d_idx == IDX_TRIM_V) || (d_idx == IDX_INIT1_NV) || (d_idx == IDX_INIT2_NV) ||
                     (d_idx == IDX_PMC) || (d_idx == IDX_INIT3_V) || (d_idx == IDX_INIT3_NV) ||
                     (d_idx == IDX_INIT4_V) || (d_idx == IDX_INIT4_NV));
  assign is_periph = data_ok && (d_idx >= IDX_PERIPH_FIRST) && !is_local; // RULE_04
  assign ee_upper_locked = init_one_v_reg[INIT1_UBD_BIT] && (d_idx >= IDX_EE_UPPER);

  // other peripherals answer through a strobed side port
  assign PERIPH_SEL   = is_periph && (((phase_reg == PH_ONE) && !dp_write_reg) || commit_wr); // RULE_04
  assign PERIPH_WE    = is_periph && commit_wr;
  assign PERIPH_ADDR  = d_idx;
  assign PERIPH_WDATA = wd_reg;

  mmp_byte_mem #(.DEPTH(SRAM_DEPTH), .AW(6)) u_sram (
    .clk   (CORE_CLK),
    .we    (commit_wr && is_sram),
    .addr  (dp_idx_reg[5:0]),
    .wdata (wd_reg),
    .rdata (sram_rdata)
  );

  // upper data EEPROM half is write-locked by the init one lock bit
  mmp_byte_mem #(.DEPTH(EE_DEPTH), .AW(6)) u_data_ee (
    .clk   (CORE_CLK),
    .we    (commit_wr && is_ee && !ee_upper_locked),
    .addr  (dp_idx_reg[5:0]),
    .wdata (wd_reg),
    .rdata (ee_rdata)
  );

  // code space, vectors included, is only writable in programming mode
  mmp_byte_mem #(.DEPTH(CODE_DEPTH), .AW(10)) u_code_ee (
    .clk   (CORE_CLK),
    .we    (commit_wr && is_code && PROG_MODE),
    .addr  (dp_idx_reg[9:0]),
    .wdata (wd_reg),
    .rdata (code_rdata)
  );

  // local register read mux
  always_comb begin
    local_rdata = 8'h00;
    case (d_idx)
      IDX_PORT_DATA: local_rdata = port_data_reg;
      IDX_PORT_DIR:  local_rdata = port_dir_reg;
      IDX_INIT1_V:   local_rdata = init_one_v_reg; // RULE_05
      IDX_TRIM_V:    local_rdata = trim_v_reg; // RULE_06
      IDX_INIT1_NV:  local_rdata = init_one_nv_reg; // RULE_05
      IDX_INIT2_NV:  local_rdata = init_two_nv_reg;
      IDX_INIT3_V:   local_rdata = init_three_v_reg; // RULE_07
      IDX_INIT3_NV:  local_rdata = init_three_nv_reg; // RULE_07
      IDX_INIT4_V:   local_rdata = init_four_v_reg; // RULE_08
      IDX_INIT4_NV:  local_rdata = init_four_nv_reg; // RULE_08
      default:       local_rdata = 8'h00; // clear location reads zero
    endcase
  end

  // read data register; unmapped addresses answer zero with OKAY
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      hrdata_reg <= 32'h00000000;
    end else if (capture_rd) begin
      if (is_sram) hrdata_reg <= {24'h000000, sram_rdata};
      else if (is_ee) hrdata_reg <= {24'h000000, ee_rdata};
      else if (is_code) hrdata_reg <= {24'h000000, code_rdata};
      else if (is_local) hrdata_reg <= {24'h000000, local_rdata};
      else if (is_periph) hrdata_reg <= {24'h000000, PERIPH_RDATA};
      else hrdata_reg <= 32'h00000000;
    end
  end

  // non-volatile copies: factory contents at reset, writable only while programming
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      init_one_nv_reg   <= INIT1_NV_RST;
      init_two_nv_reg   <= INIT2_NV_RST;
      init_three_nv_reg <= INIT3_NV_RST;
      init_four_nv_reg  <= INIT4_NV_RST;
    end else if (commit_wr && is_local && PROG_MODE) begin
      if (d_idx == IDX_INIT1_NV) init_one_nv_reg <= wd_reg; // RULE_05
      if (d_idx == IDX_INIT2_NV) init_two_nv_reg <= wd_reg;
      if (d_idx == IDX_INIT3_NV) init_three_nv_reg <= wd_reg; // RULE_07
      if (d_idx == IDX_INIT4_NV) init_four_nv_reg <= wd_reg; // RULE_08
    end
  end

  // init four shadow is loaded in the very first cycle after reset
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      init_four_v_reg <= 8'h00;
    end else if (ld_state_reg == LD_PINS) begin
      init_four_v_reg <= init_four_nv_reg; // RULE_12
    end else if (commit_wr && is_local && (d_idx == IDX_INIT4_V)) begin
      init_four_v_reg <= wd_reg; // RULE_08
    end
  end

  // remaining shadows follow one cycle later
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      init_one_v_reg   <= 8'h00;
      trim_v_reg       <= 8'h00;
      init_three_v_reg <= 8'h00;
    end else if (ld_state_reg == LD_REST) begin
      init_one_v_reg   <= init_one_nv_reg;
      trim_v_reg       <= init_two_nv_reg;
      init_three_v_reg <= init_three_nv_reg;
    end else if (commit_wr && is_local) begin
      if (d_idx == IDX_INIT1_V) init_one_v_reg <= wd_reg; // RULE_05
      // trim stays locked unless the clock-adjust bit opens it
      if ((d_idx == IDX_TRIM_V) && init_one_v_reg[INIT1_CLK_ADJ_BIT]) trim_v_reg <= wd_reg; // RULE_06
      if (d_idx == IDX_INIT3_V) init_three_v_reg <= wd_reg; // RULE_07
    end
  end

  // port direction and data; pin defaults land on lines zero and five
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      port_dir_reg  <= PORT_RST; // RULE_02
      port_data_reg <= PORT_RST;
    end else if (ld_state_reg == LD_PINS) begin
      port_dir_reg[PIN_ONE]  <= init_four_nv_reg[INIT4_DIR_BIT]; // RULE_11
      port_dir_reg[PIN_TWO]  <= init_four_nv_reg[INIT4_DIR_BIT]; // RULE_11
      port_data_reg[PIN_ONE] <= init_four_nv_reg[INIT4_LEV1_BIT]; // RULE_11
      port_data_reg[PIN_TWO] <= init_four_nv_reg[INIT4_LEV2_BIT]; // RULE_11
    end else if (commit_wr && is_local) begin
      if (d_idx == IDX_PORT_DIR) port_dir_reg <= wd_reg;
      if (d_idx == IDX_PORT_DATA) port_data_reg <= wd_reg;
    end
  end

  // pin drive: output follows data, input uses data as pull-up select
  assign PORT_OE     = port_dir_reg; // RULE_03
  assign PORT_OUT    = port_data_reg & port_dir_reg; // RULE_03
  assign PORT_PULLUP = port_data_reg & ~port_dir_reg; // RULE_01

  // power mode clear is a one-cycle strobe on any write to its location
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      pmc_reg <= 1'b0;
    end else begin
      pmc_reg <= commit_wr && is_local && (d_idx == IDX_PMC); // RULE_09
    end
  end
  assign POWER_MODE_CLEAR = pmc_reg;

  // vector fetch address, registered one cycle after the source select
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      vec_reg <= VEC_TIMER0;
    end else begin
      case (VECTOR_SOURCE)
        3'h0:    vec_reg <= VEC_TIMER0; // RULE_10
        3'h1:    vec_reg <= VEC_PWM;
        3'h2:    vec_reg <= VEC_WAKEUP;
        3'h3:    vec_reg <= VEC_SOFT;
        3'h4:    vec_reg <= VEC_CONV;
        default: vec_reg <= VEC_SOFT; // undefined sources fall back to the software vector
      endcase
    end
  end
  assign VECTOR_ADDRESS = vec_reg;

  assign INIT_ONE   = init_one_v_reg;
  assign CLOCK_TRIM = trim_v_reg;
  assign INIT_THREE = init_three_v_reg;
  assign INIT_FOUR  = init_four_v_reg;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  sequence s_load;
    (ld_state_reg == LD_PINS) ##1 (ld_state_reg == LD_REST) ##1 (ld_state_reg == LD_RUN);
  endsequence
  property p_load_order;
    $fell(SRST) |-> s_load;
  endproperty
  a_load_order: assert property (p_load_order) else $error("reset load order wrong"); // RULE_12

  property p_shadow4;
    (ld_state_reg == LD_PINS && !SRST) |=> (init_four_v_reg == $past(init_four_nv_reg));
  endproperty
  a_shadow4: assert property (p_shadow4) else $error("init four shadow not loaded"); // RULE_12

  property p_inputs;
    (ld_state_reg == LD_PINS && !SRST && !init_four_nv_reg[INIT4_DIR_BIT]) |=>
      (!PORT_OE[PIN_ONE] && !PORT_OE[PIN_TWO] && PORT_PULLUP[PIN_ONE] == $past(init_four_nv_reg[INIT4_LEV1_BIT]));
  endproperty
  a_inputs: assert property (p_inputs) else $error("default input setup wrong"); // RULE_01

  property p_tristate;
    (ld_state_reg == LD_PINS && !SRST && init_four_nv_reg[7:5] == 3'h0) |=>
      (PORT_OE[PIN_TWO] == 1'b0 && PORT_PULLUP[PIN_TWO] == 1'b0 && PORT_PULLUP[PIN_ONE] == 1'b0);
  endproperty
  a_tristate: assert property (p_tristate) else $error("pins not tri-state"); // RULE_02

  property p_outputs;
    (ld_state_reg == LD_PINS && !SRST && init_four_nv_reg[INIT4_DIR_BIT]) |=>
      (PORT_OE[PIN_TWO] && PORT_OUT[PIN_TWO] == $past(init_four_nv_reg[INIT4_LEV2_BIT]) && !PORT_PULLUP[PIN_TWO]);
  endproperty
  a_outputs: assert property (p_outputs) else $error("default output setup wrong"); // RULE_03

  property p_pmc;
    (commit_wr && data_ok && d_idx == IDX_PMC) |=> POWER_MODE_CLEAR ##1 !POWER_MODE_CLEAR;
  endproperty
  a_pmc: assert property (p_pmc) else $error("power mode clear strobe wrong"); // RULE_09

  property p_trim_lock;
    (commit_wr && data_ok && d_idx == IDX_TRIM_V && !init_one_v_reg[INIT1_CLK_ADJ_BIT]) |=> $stable(trim_v_reg);
  endproperty
  a_trim_lock: assert property (p_trim_lock) else $error("trim written while locked"); // RULE_06

  property p_init1_read;
    (capture_rd && data_ok && d_idx == IDX_INIT1_V) |=> (HREADYOUT && HRDATA[7:0] == init_one_v_reg);
  endproperty
  a_init1_read: assert property (p_init1_read) else $error("init one read wrong"); // RULE_05

  property p_vector;
    (VECTOR_SOURCE == 3'h4) |=> (VECTOR_ADDRESS == VEC_CONV);
  endproperty
  a_vector: assert property (p_vector) else $error("converter vector wrong"); // RULE_10

  property p_periph;
    (phase_reg == PH_ONE && !dp_write_reg && data_ok && d_idx == 8'h9D) |-> (PERIPH_SEL && !PERIPH_WE);
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral read not strobed"); // RULE_04

  property p_init4_nv;
    (commit_wr && PROG_MODE && data_ok && d_idx == IDX_INIT4_NV) |=> (init_four_nv_reg == $past(wd_reg));
  endproperty
  a_init4_nv: assert property (p_init4_nv) else $error("init four copy not written"); // RULE_08
endmodule
`default_nettype wire

// *** memory_map_and_port_defaults_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module memory_map_and_port_defaults_tb_top;
  import mmp_pkg::*;

  logic        core_clk;
  logic        srst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        prog_mode;
  logic        periph_sel;
  logic        periph_we;
  logic [7:0]  periph_addr;
  logic [7:0]  periph_wdata;
  logic [7:0]  periph_rdata;
  logic        power_mode_clear;
  logic [2:0]  vec_src;
  logic [11:0] vec_addr;
  logic [7:0]  port_out;
  logic [7:0]  port_oe;
  logic [7:0]  port_pullup;
  logic [7:0]  init_one;
  logic [7:0]  clock_trim;
  logic [7:0]  init_three;
  logic [7:0]  init_four;
  logic        load_done;
  logic [31:0] rd_q;
  logic [7:0]  seen_addr;
  logic [7:0]  seen_wdata;
  logic        seen_we;
  logic        d;
  logic        l1;
  logic        l2;
  int          seen_cnt;
  int          num_errors;
  int          cmp_count;
  int          cycles;

  mmp_memory_map i_mmp_memory_map (
    .CORE_CLK(core_clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp),
    .HRDATA(hrdata), .PROG_MODE(prog_mode), .PERIPH_SEL(periph_sel), .PERIPH_WE(periph_we),
    .PERIPH_ADDR(periph_addr), .PERIPH_WDATA(periph_wdata), .PERIPH_RDATA(periph_rdata),
    .POWER_MODE_CLEAR(power_mode_clear), .VECTOR_SOURCE(vec_src), .VECTOR_ADDRESS(vec_addr), .PORT_OUT(port_out),
    .PORT_OE(port_oe), .PORT_PULLUP(port_pullup), .INIT_ONE(init_one), .CLOCK_TRIM(clock_trim),
    .INIT_THREE(init_three), .INIT_FOUR(init_four), .LOAD_DONE(load_done)
  );

  // 25 mhz core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // record the last strobe seen on the peripheral port
  always @(posedge core_clk) begin
    if (periph_sel === 1'b1) begin
      seen_addr  <= periph_addr;
      seen_we    <= periph_we;
      seen_wdata <= periph_wdata;
      seen_cnt   <= seen_cnt + 1;
    end
  end

  // a hung handshake would otherwise stall the run forever
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      print_verdict();
    end
  end

  function automatic logic [31:0] da(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction

  function automatic logic [31:0] pa(input logic [11:0] idx);
    return {17'h0, 1'b1, idx, 2'b00};
  endfunction

  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_sig(input string nm, input logic [11:0] e, input logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one single transfer; entered just after a rising edge, left just after the completing edge
  // waits as long as the slave needs; only the cycle ceiling ends a hung wait
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= {24'h0, wd};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd_q = hrdata;
    chk_sig("hresp", 12'h0, {11'h0, hresp});
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] wd);
    xfer(1'b1, a, wd);
  endtask

  task automatic rdc(input string nm, input logic [31:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk_reg(nm, {24'h0, e}, rd_q);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    srst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
    hwdata = 32'h0; prog_mode = 1'b0; periph_rdata = 8'hC3; vec_src = 3'h0;
    num_errors = 0; cmp_count = 0;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    // first edge after release applies the pin defaults before anything else
    @(posedge core_clk);
    #1;
    chk_sig("init_four early", {4'h0, INIT4_NV_RST}, {4'h0, init_four});
    chk_sig("port_oe reset", 12'h0, {4'h0, port_oe});
    chk_sig("port_pullup reset", 12'h0, {4'h0, port_pullup});
    chk_sig("load_done early", 12'h0, {11'h0, load_done});
    @(posedge core_clk);
    #1;
    chk_sig("load_done", 12'h1, {11'h0, load_done});
    // factory copies and their shadows
    rdc("init one nv", da(IDX_INIT1_NV), INIT1_NV_RST);
    rdc("init one v", da(IDX_INIT1_V), INIT1_NV_RST);
    rdc("trim v", da(IDX_TRIM_V), INIT2_NV_RST);
    rdc("init three v", da(IDX_INIT3_V), INIT3_NV_RST);
    rdc("init four v", da(IDX_INIT4_V), INIT4_NV_RST);
    rdc("init four nv", da(IDX_INIT4_NV), INIT4_NV_RST);
    chk_sig("hresp", 12'h0, {11'h0, hresp});
    // trim is locked until the adjust bit is set
    wr(da(IDX_TRIM_V), 8'h5A);
    rdc("trim locked", da(IDX_TRIM_V), INIT2_NV_RST);
    wr(da(IDX_INIT1_V), 8'h80);
    wr(da(IDX_TRIM_V), 8'h5A);
    rdc("trim open", da(IDX_TRIM_V), 8'h5A);
    chk_sig("clock_trim", 12'h05A, {4'h0, clock_trim});
    chk_sig("init_one", 12'h080, {4'h0, init_one});
    wr(da(IDX_INIT3_V), 8'h2D);
    rdc("init three v rw", da(IDX_INIT3_V), 8'h2D);
    chk_sig("init_three", 12'h02D, {4'h0, init_three});
    wr(da(IDX_INIT4_V), 8'hA7);
    rdc("init four v rw", da(IDX_INIT4_V), 8'hA7);
    chk_sig("init_four", 12'h0A7, {4'h0, init_four});
    // non-volatile copies only change in programming mode
    wr(da(IDX_INIT1_NV), 8'h55);
    rdc("init one nv locked", da(IDX_INIT1_NV), INIT1_NV_RST);
    prog_mode <= 1'b1;
    wr(da(IDX_INIT1_NV), 8'h55);
    rdc("init one nv prog", da(IDX_INIT1_NV), 8'h55);
    wr(da(IDX_INIT3_NV), 8'h1B);
    rdc("init three nv prog", da(IDX_INIT3_NV), 8'h1B);
    wr(da(IDX_INIT4_NV), 8'hF3);
    rdc("init four nv prog", da(IDX_INIT4_NV), 8'hF3);
    // every combination of direction and the two levels on lines zero and five
    for (int c = 0; c < 8; c++) begin
      d  = c[2];
      l2 = c[1];
      l1 = c[0];
      wr(da(IDX_PORT_DIR), {2'b00, d, 4'h0, d});
      wr(da(IDX_PORT_DATA), {2'b00, l2, 4'h0, l1});
      #1;
      chk_sig("port_oe", {6'h0, d, 4'h0, d}, {4'h0, port_oe});
      chk_sig("port_out", {6'h0, d & l2, 4'h0, d & l1}, {4'h0, port_out});
      chk_sig("port_pullup", {6'h0, ~d & l2, 4'h0, ~d & l1}, {4'h0, port_pullup});
    end
    // power mode clear pulses for one cycle after the write
    wr(da(IDX_PMC), 8'h01);
    #1;
    chk_sig("pmc pulse", 12'h1, {11'h0, power_mode_clear});
    @(posedge core_clk);
    #1;
    chk_sig("pmc end", 12'h0, {11'h0, power_mode_clear});
    // vector fetch addresses, two bytes apart
    for (int s = 0; s < 5; s++) begin
      @(posedge core_clk);
      vec_src <= s[2:0];
      @(posedge core_clk);
      #1;
      chk_sig("vector", 12'hFF6 + {8'h0, s[2:0], 1'b0}, vec_addr);
    end
    // memory windows at both ends of the SRAM and data EEPROM ranges, code at C00 and FFE
    wr(da(8'h00), 8'h11);
    wr(da(IDX_SRAM_LAST), 8'h22);
    wr(da(IDX_EE_FIRST), 8'h33);
    wr(da(IDX_EE_LAST), 8'h44);
    wr(pa(IDX_CODE_FIRST), 8'h66);
    wr(pa(VEC_CONV), 8'h77);
    rdc("sram first", da(8'h00), 8'h11);
    rdc("sram last", da(IDX_SRAM_LAST), 8'h22);
    rdc("ee first", da(IDX_EE_FIRST), 8'h33);
    rdc("ee last", da(IDX_EE_LAST), 8'h44);
    rdc("code first", pa(IDX_CODE_FIRST), 8'h66);
    rdc("vector byte", pa(VEC_CONV), 8'h77);
    // the lock bit in init one shields the upper data EEPROM half
    wr(da(IDX_INIT1_V), 8'h84);
    wr(da(IDX_EE_LAST), 8'h55);
    rdc("ee upper locked", da(IDX_EE_LAST), 8'h44);
    wr(32'h0001_0000, 8'h99);
    rdc("unmapped", 32'h0001_0000, 8'h00);
    // peripheral registers are reached through the same space
    rdc("periph read", da(8'h9D), 8'hC3);
    #1;
    chk_sig("periph rd addr", 12'h09D, {4'h0, seen_addr});
    chk_sig("periph rd we", 12'h0, {11'h0, seen_we});
    wr(da(8'hA6), 8'h3C);
    #1;
    chk_sig("periph wr addr", 12'h0A6, {4'h0, seen_addr});
    chk_sig("periph wr data", 12'h03C, {4'h0, seen_wdata});
    chk_sig("periph wr we", 12'h1, {11'h0, seen_we});
    // exactly one strobe per peripheral transfer, none for local or memory hits
    chk_sig("periph strobes", 12'h2, seen_cnt[11:0]);
    print_verdict();
  end
endmodule
`default_nettype wire
